/* bench/duart_irq_status_bench.sv */
`timescale 1ns/1ns
module duart_irq_status_bench;
	logic clk = 1'h0;
	logic rstn = 1'h0;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic wr;
	logic rd;
	logic ct_stop;
	logic irq_n;
	logic [3:0] pins = 4'h0;
	logic brk_a = 1'h0;
	logic brk_b = 1'h0;
	logic ct_zero = 1'h0;
	// {tx b, rx b fill, rx b timeout, tx a, rx a fill, rx a timeout}
	logic [5:0] lvl = 6'h00;
	logic [7:0] d;
	int failures = 0;
	int tests_run = 0;
	int cycles = 0;
	// level inputs, mask, expected status, expected irq_n
	logic [22:0] rows [5] = '{{6'h20, 8'h10, 8'h10, 1'h0},
		{6'h10, 8'hDF, 8'h20, 1'h1}, {6'h09, 8'h02, 8'h22, 1'h0},
		{6'h06, 8'hFC, 8'h03, 1'h1}, {6'h00, 8'hFF, 8'h00, 1'h1}};

	always #4 clk = ~clk;

	duart_irq_status duart_irq_status_inst (
		.SYS_CLK_IN(clk), .RSTN_IN(rstn), .ADDR_IN(addr),
		.WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
		.INPUT_PIN_IN(pins), .BRK_CHANGE_A_IN(brk_a),
		.BRK_CHANGE_B_IN(brk_b), .RX_A_FILL_IN(lvl[1]),
		.RX_A_TIMEOUT_IN(lvl[0]), .RX_B_FILL_IN(lvl[4]),
		.RX_B_TIMEOUT_IN(lvl[3]), .TX_A_LEVEL_IN(lvl[2]),
		.TX_B_LEVEL_IN(lvl[5]), .CT_ZERO_IN(ct_zero),
		.CT_STOP_OUT(ct_stop), .IRQ_N_OUT(irq_n));

	host_model host_model_inst (.clk_in(clk), .addr_out(addr),
		.wdata_out(wdata), .wr_out(wr), .rd_out(rd), .rdata_in(rdata));

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
		host_model_inst.read_reg(a, d);
		chk(d, exp);
	endtask : rd_chk

	// hang guard, the run needs well under a thousand cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			failures++;
			stop_test();
		end
	end

	initial
	begin
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk({6'h00, ct_stop, irq_n}, 8'h01);
		@(posedge clk);
		rstn <= 1'h1;
		rd_chk(irq_pkg::OFS_INTERRUPT, irq_pkg::STATUS_RST);
		$display("test reset done");
		foreach (rows[i])
		begin
			@(posedge clk);
			lvl <= rows[i][22:17];
			host_model_inst.write_reg(irq_pkg::OFS_INTERRUPT, rows[i][16:9]);
			rd_chk(irq_pkg::OFS_INTERRUPT, rows[i][8:1]);
			chk({7'h00, irq_n}, {7'h00, rows[i][0]});
		end
		$display("test level sources done");
		host_model_inst.write_reg(irq_pkg::OFS_INTERRUPT, 8'h00);
		@(posedge clk);
		brk_a <= 1'h1;
		brk_b <= 1'h1;
		@(posedge clk);
		brk_a <= 1'h0;
		brk_b <= 1'h0;
		rd_chk(irq_pkg::OFS_INTERRUPT, 8'h44);
		chk({7'h00, irq_n}, 8'h01);
		host_model_inst.write_reg(irq_pkg::OFS_INTERRUPT, 8'h04);
		host_model_inst.command(8'h02);
		rd_chk(irq_pkg::OFS_INTERRUPT, 8'h04);
		chk({7'h00, irq_n}, 8'h00);
		host_model_inst.command(8'h01);
		rd_chk(irq_pkg::OFS_INTERRUPT, 8'h00);
		chk({7'h00, irq_n}, 8'h01);
		$display("test break flags done");
		@(posedge clk);
		ct_zero <= 1'h1;
		@(posedge clk);
		ct_zero <= 1'h0;
		rd_chk(irq_pkg::OFS_INTERRUPT, 8'h08);
		host_model_inst.command(8'h04);
		@(negedge clk);
		chk({7'h00, ct_stop}, 8'h01);
		rd_chk(irq_pkg::OFS_INTERRUPT, 8'h00);
		$display("test counter mode done");
		host_model_inst.write_reg(irq_pkg::OFS_AUX_CONTROL, 8'h40);
		for (int n = 0; n < 2; n++)
		begin
			@(posedge clk);
			ct_zero <= 1'h1;
			@(posedge clk);
			ct_zero <= 1'h0;
			rd_chk(irq_pkg::OFS_INTERRUPT, n == 1 ? 8'h08 : 8'h00);
		end
		host_model_inst.command(8'h04);
		@(negedge clk);
		chk({7'h00, ct_stop}, 8'h00);
		rd_chk(irq_pkg::OFS_INTERRUPT, 8'h00);
		$display("test timer mode done");
		host_model_inst.write_reg(irq_pkg::OFS_AUX_CONTROL, 8'h01);
		@(posedge clk);
		pins <= 4'h2;
		repeat (8) @(posedge clk);
		rd_chk(irq_pkg::OFS_INTERRUPT, 8'h00);
		@(posedge clk);
		pins <= 4'h3;
		repeat (8) @(posedge clk);
		rd_chk(irq_pkg::OFS_INTERRUPT, 8'h80);
		rd_chk(irq_pkg::OFS_INPUT_CHANGE, 8'h33);
		rd_chk(irq_pkg::OFS_INTERRUPT, 8'h00);
		$display("test input change done");
		// mid-run reset with a masked break pending
		@(posedge clk);
		brk_a <= 1'h1;
		@(posedge clk);
		brk_a <= 1'h0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk({7'h00, irq_n}, 8'h00);
		@(posedge clk);
		rstn <= 1'h0;
		repeat (3) @(posedge clk);
		rstn <= 1'h1;
		@(negedge clk);
		chk({6'h00, ct_stop, irq_n}, 8'h01);
		rd_chk(irq_pkg::OFS_INTERRUPT, irq_pkg::STATUS_RST);
		$display("test mid-run reset done");
		stop_test();
	end
endmodule : duart_irq_status_bench

/* bench/host_model.sv */
`timescale 1ns/1ns
module host_model (
	// clock
	input wire logic clk_in,
	// register port
	output logic [3:0] addr_out,
	output logic [7:0] wdata_out,
	output logic wr_out,
	output logic rd_out,
	input wire logic [7:0] rdata_in
);
	initial
	begin
		addr_out = 4'h0;
		wdata_out = 8'h00;
		wr_out = 1'h0;
		rd_out = 1'h0;
	end

	// strobes are one cycle, never together
	task automatic write_reg(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_in);
		addr_out <= a;
		wdata_out <= v;
		wr_out <= 1'h1;
		@(posedge clk_in);
		wr_out <= 1'h0;
	endtask : write_reg

	// data sampled mid-cycle, after the answer has settled
	task automatic read_reg(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk_in);
		addr_out <= a;
		rd_out <= 1'h1;
		@(posedge clk_in);
		rd_out <= 1'h0;
		@(negedge clk_in);
		v = rdata_in;
	endtask : read_reg

	task automatic command(input logic [7:0] v);
		write_reg(irq_pkg::OFS_COMMAND, v);
	endtask : command
endmodule : host_model

/* hdl/duart_irq_status.sv */
// Functional notes
// - irq output low while any status bit and its mask bit are both one
// - status read returns raw sources, never filtered by the mask
// - reset clears every status bit
// - status readable at offset 5, eight source bits
// - bit 7 sets on an enabled input pin change
// - reading the input change register clears bit 7
// - bit 6 sets on channel B break start or end
// - bit 6 holds until the channel B reset break change command
// - bit 5 follows channel B receive fill level or watchdog timeout
// - receive bits are separate from the receiver ready flag
// - bit 4 follows channel B transmit interrupt level
// - counter mode: bit 3 sets at terminal count
// - counter mode: stop command halts counter and clears bit 3
// - timer mode: bit 3 sets on every second arrival at zero
// - timer mode: stop command clears bit 3, counter keeps running
// - bit 2 sets on channel A break change, cleared by its command
// - bit 1 follows channel A receive fill level or watchdog timeout
// - bit 0 follows channel A transmit interrupt level
// - mask written at offset 5, one enable per status bit
`timescale 1ns/1ns
module duart_irq_status (
	// clock and reset
	input wire logic SYS_CLK_IN,
	input wire logic RSTN_IN,
	// register port
	input wire logic [3:0] ADDR_IN,
	input wire logic [7:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	output logic [7:0] RDATA_OUT,
	// input port pins
	input wire logic [3:0] INPUT_PIN_IN,
	// receiver and transmitter sources
	input wire logic BRK_CHANGE_A_IN,
	input wire logic BRK_CHANGE_B_IN,
	input wire logic RX_A_FILL_IN,
	input wire logic RX_A_TIMEOUT_IN,
	input wire logic RX_B_FILL_IN,
	input wire logic RX_B_TIMEOUT_IN,
	input wire logic TX_A_LEVEL_IN,
	input wire logic TX_B_LEVEL_IN,
	// counter/timer
	input wire logic CT_ZERO_IN,
	output logic CT_STOP_OUT,
	// interrupt to host
	output logic IRQ_N_OUT
);

	irq_pkg::bus_req_t req;
	irq_pkg::status_t status;
	irq_pkg::half_t phase_r;
	logic [7:0] mask_r;
	logic [7:0] aux_r;
	logic [7:0] rdata_r;
	logic irq_n_r;
	logic ct_stop_r;
	logic [3:0] pin_s1_r;
	logic [3:0] pin_s2_r;
	logic [3:0] pin_s3_r;
	logic [3:0] pin_state_r;
	logic [3:0] pin_change;
	logic [3:0] delta_r;
	logic [3:0] lvl_r;
	logic [3:0] sticky_set;
	logic [3:0] sticky_clr;
	logic [3:0] sticky;
	logic timer_mode;
	logic chg_read;
	logic cmd_wr;
	logic ct_set;

	assign req = '{addr: ADDR_IN, wdata: WDATA_IN, wr: WR_IN, rd: RD_IN};
	assign timer_mode = aux_r[irq_pkg::AUX_TIMER_BIT];
	assign chg_read = req.rd && (req.addr == irq_pkg::OFS_INPUT_CHANGE);
	assign cmd_wr = req.wr && (req.addr == irq_pkg::OFS_COMMAND);

	// three stages; a change counts once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_pin
			always_ff @(posedge SYS_CLK_IN)
			begin
				if (!RSTN_IN)
				begin
					pin_s1_r[g] <= 1'b0;
					pin_s2_r[g] <= 1'b0;
					pin_s3_r[g] <= 1'b0;
				end
				else
				begin
					pin_s1_r[g] <= INPUT_PIN_IN[g];
					pin_s2_r[g] <= pin_s1_r[g];
					pin_s3_r[g] <= pin_s2_r[g];
				end
			end
			assign pin_change[g] = (pin_s2_r[g] == pin_s3_r[g])
				&& (pin_s3_r[g] != pin_state_r[g]);
		end
	endgenerate

	// settled pin level; state after reset is low, so a high pin at
	// release reports one change
	// only an agreed change moves it, so a one-cycle glitch is ignored
	always_ff @(posedge SYS_CLK_IN)
	begin
		if (!RSTN_IN)
			pin_state_r <= irq_pkg::PIN_RST;
		else
			pin_state_r <= pin_state_r ^ pin_change;
	end

	// delta bits of the input change register, cleared by its read
	always_ff @(posedge SYS_CLK_IN)
	begin
		if (!RSTN_IN)
			delta_r <= 4'h0;
		else
			delta_r <= pin_change | (delta_r & {4{~chg_read}});
	end

	// software-written control: mask and aux control
	always_ff @(posedge SYS_CLK_IN)
	begin
		if (!RSTN_IN)
		begin
			mask_r <= irq_pkg::MASK_RST;
			aux_r <= irq_pkg::AUX_RST;
		end
		else if (req.wr)
		begin
			if (req.addr == irq_pkg::OFS_INTERRUPT)
				mask_r <= req.wdata;
			if (req.addr == irq_pkg::OFS_AUX_CONTROL)
				aux_r <= req.wdata;
		end
	end

	// timer half-period tracking, held in first half in counter mode
	always_ff @(posedge SYS_CLK_IN)
	begin
		if (!RSTN_IN)
			phase_r <= irq_pkg::PH_FIRST;
		else if (!timer_mode)
			phase_r <= irq_pkg::PH_FIRST;
		else if (CT_ZERO_IN)
		begin
			unique case (phase_r)
				irq_pkg::PH_FIRST: phase_r <= irq_pkg::PH_SECOND;
				irq_pkg::PH_SECOND: phase_r <= irq_pkg::PH_FIRST;
			endcase
		end
	end

	// every second zero in timer mode
	assign ct_set = CT_ZERO_IN
		&& (!timer_mode || phase_r == irq_pkg::PH_SECOND);

	// enabled pin change sets bit 7
	// break change B sets bit 6
	// break change A sets bit 2
	assign sticky_set = {
		|(pin_change & aux_r[irq_pkg::AUX_CHG_EN_LSB +: 4]),
		BRK_CHANGE_B_IN,
		ct_set,
		BRK_CHANGE_A_IN
	};

	// change register read clears bit 7
	// only the channel command clears a break bit
	assign sticky_clr = {
		chg_read,
		cmd_wr && req.wdata[irq_pkg::CMD_RST_BRK_B],
		cmd_wr && req.wdata[irq_pkg::CMD_STOP_CT],
		cmd_wr && req.wdata[irq_pkg::CMD_RST_BRK_A]
	};

	sticky_flags #(
		.WIDTH(4)
	) sticky_flags_inst (
		.clk_in(SYS_CLK_IN),
		.rstn_in(RSTN_IN),
		.set_in(sticky_set),
		.clr_in(sticky_clr),
		.flag_out(sticky)
	);

	// level sources, kept apart from receiver ready flags
	always_ff @(posedge SYS_CLK_IN)
	begin
		if (!RSTN_IN)
			lvl_r <= 4'h0;
		else
		begin
			lvl_r <= {RX_B_FILL_IN | RX_B_TIMEOUT_IN, TX_B_LEVEL_IN,
				RX_A_FILL_IN | RX_A_TIMEOUT_IN, TX_A_LEVEL_IN};
		end
	end

	assign status = '{
		ip_change: sticky[3],
		brk_b: sticky[2],
		rx_b: lvl_r[3],
		tx_b: lvl_r[2],
		ctr_ready: sticky[1],
		brk_a: sticky[0],
		rx_a: lvl_r[1],
		tx_a: lvl_r[0]
	};

	// timer keeps running, so stop goes out only in counter mode
	always_ff @(posedge SYS_CLK_IN)
	begin
		if (!RSTN_IN)
			ct_stop_r <= 1'b0;
		else
			ct_stop_r <= cmd_wr && req.wdata[irq_pkg::CMD_STOP_CT]
				&& !timer_mode;
	end

	// read data stand one cycle after the strobe, zero otherwise
	always_ff @(posedge SYS_CLK_IN)
	begin
		if (!RSTN_IN)
			rdata_r <= irq_pkg::RDATA_IDLE;
		else if (!req.rd)
			rdata_r <= irq_pkg::RDATA_IDLE;
		else
		begin
			unique case (req.addr)
				irq_pkg::OFS_INTERRUPT: rdata_r <= status;
				irq_pkg::OFS_INPUT_CHANGE: rdata_r <= {delta_r, pin_state_r};
				default: rdata_r <= irq_pkg::RDATA_IDLE;
			endcase
		end
	end

	// masked status drives the low-active output
	always_ff @(posedge SYS_CLK_IN)
	begin
		if (!RSTN_IN)
			irq_n_r <= 1'b1;
		else
			irq_n_r <= ~|(status & mask_r);
	end

	assign RDATA_OUT = rdata_r;
	assign CT_STOP_OUT = ct_stop_r;
	assign IRQ_N_OUT = irq_n_r;

	default clocking cb @(posedge SYS_CLK_IN);
	endclocking
	default disable iff (!RSTN_IN);

	a_irq_assert: assert property (
		|(status & mask_r) |=> !IRQ_N_OUT)
		else $error("irq not driven low for masked source");
	a_irq_release: assert property (
		(status & mask_r) == 8'h00 |=> IRQ_N_OUT)
		else $error("irq stays low with no masked source");
	a_status_raw: assert property (
		req.rd && req.addr == irq_pkg::OFS_INTERRUPT
		|=> RDATA_OUT == $past(status))
		else $error("status read differs from raw status");
	a_reset_clear: assert property (disable iff (1'b0)
		!RSTN_IN |=> status == irq_pkg::STATUS_RST)
		else $error("status not cleared by reset");
	a_pin_change: assert property (
		|(pin_change & aux_r[3:0]) |=> status.ip_change)
		else $error("enabled pin change did not set bit 7");
	a_chg_read: assert property (
		chg_read && !(|(pin_change & aux_r[3:0])) |=> !status.ip_change)
		else $error("change register read left bit 7 set");
	a_brk_hold: assert property (
		status.brk_b && !(cmd_wr && req.wdata[irq_pkg::CMD_RST_BRK_B])
		|=> status.brk_b)
		else $error("break B bit dropped without command");
	a_rx_follow: assert property (
		(RX_B_FILL_IN || RX_B_TIMEOUT_IN) |=> status.rx_b)
		else $error("receive B source not shown");
	a_timer_second: assert property (
		timer_mode && CT_ZERO_IN && phase_r == irq_pkg::PH_FIRST
		&& !status.ctr_ready ##1 timer_mode |-> !status.ctr_ready)
		else $error("timer set bit 3 on first zero");
	a_stop_clear: assert property (
		cmd_wr && req.wdata[irq_pkg::CMD_STOP_CT] && !ct_set
		|=> !status.ctr_ready && (CT_STOP_OUT == !$past(timer_mode)))
		else $error("stop command wrong");

	c_irq_low: cover property (!IRQ_N_OUT ##1 IRQ_N_OUT);
	c_timer_set: cover property (timer_mode && ct_set);
	c_chg_clear: cover property (status.ip_change ##1 chg_read);

endmodule : duart_irq_status

/* hdl/irq_pkg.sv */
package irq_pkg;

	// register offsets on the plain register port
	localparam logic [3:0] OFS_INPUT_CHANGE = 4'h4;
	localparam logic [3:0] OFS_AUX_CONTROL = 4'h4;
	localparam logic [3:0] OFS_INTERRUPT = 4'h5;
	localparam logic [3:0] OFS_COMMAND = 4'hE;

	// values after reset
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [7:0] AUX_RST = 8'h00;
	localparam logic [7:0] RDATA_IDLE = 8'h00;
	localparam logic [3:0] PIN_RST = 4'h0;

	// field positions
	localparam int AUX_TIMER_BIT = 6;
	localparam int AUX_CHG_EN_LSB = 0;
	localparam int CHG_DELTA_LSB = 4;
	localparam int CMD_RST_BRK_A = 0;
	localparam int CMD_RST_BRK_B = 1;
	localparam int CMD_STOP_CT = 2;

	// pin synchroniser length
	localparam int SYNC_DEPTH = 3;

	// interrupt status layout, bit 7 first
	typedef struct packed {
		logic ip_change;
		logic brk_b;
		logic rx_b;
		logic tx_b;
		logic ctr_ready;
		logic brk_a;
		logic rx_a;
		logic tx_a;
	} status_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

	typedef enum logic {
		PH_FIRST = 1'b0,
		PH_SECOND = 1'b1
	} half_t;

endpackage : irq_pkg

/* hdl/sticky_flags.sv */
`timescale 1ns/1ns
module sticky_flags #(
	parameter int WIDTH = 4
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// set and clear requests
	input wire logic [WIDTH-1:0] set_in,
	input wire logic [WIDTH-1:0] clr_in,
	// held flags
	output logic [WIDTH-1:0] flag_out
);

	logic [WIDTH-1:0] flag_r;

	// a set in the clearing cycle wins, so no event is lost
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
			flag_r <= '0;
		else
			flag_r <= set_in | (flag_r & ~clr_in);
	end

	assign flag_out = flag_r;

	a_set_wins: assert property (@(posedge clk_in)
		disable iff (!rstn_in)
		set_in[0] |=> flag_r[0])
		else $error("flag lost a set that met its clear");

endmodule : sticky_flags
